// >>> flash_id_pkg.sv
// shared constants and types for the flash identification command block
package flash_id_pkg;

  // opcodes handled here
  localparam logic [7:0] OP_WAKE_ID       = 8'hab;
  localparam logic [7:0] OP_MAKER_DEV     = 8'h90;
  localparam logic [7:0] OP_STD_ID        = 8'h9f;
  localparam logic [7:0] OP_SECURE_ENTER  = 8'h3a;
  localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;
  localparam logic [7:0] OP_TABLE_READ    = 8'h5a;

  // core clock
  localparam int CLK_PERIOD_NS = 10;

  // serial field lengths, as last bit index; STD_ID_LAST as last byte index
  localparam logic [4:0] OPCODE_LAST_BIT = 5'd7;
  localparam logic [4:0] ADDR_LAST_BIT   = 5'd23;
  localparam logic [4:0] DUMMY_LAST_BIT  = 5'd7;
  localparam logic [2:0] BYTE_LAST_BIT   = 3'd7;
  localparam logic [1:0] STD_ID_LAST     = 2'd2;

  // parameter table address width, wraps after the top entry
  localparam int TABLE_AW = 7;

  // secure sector window while in secure-sector mode
  localparam logic [23:0] SECURE_BASE = 24'h07f000;
  localparam logic [23:0] SECURE_LAST = 24'h07f1ff;

  // reset values
  localparam logic RST_DEEP_SLEEP  = 1'b0;
  localparam logic RST_SECURE_MODE = 1'b0;
  localparam logic RST_ALLOWED     = 1'b1;
  localparam logic [15:0] RST_WAKE_CNT = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_OUT   = 3'b100,
    ST_SKIP  = 3'b101
  } state_e;

  typedef enum logic [1:0] {
    OM_DEV   = 2'b00,
    OM_MAKER = 2'b01,
    OM_STD   = 2'b10,
    OM_TABLE = 2'b11
  } outmode_e;

endpackage

// >>> flash_id_cmd.sv
// identification, secure-sector and parameter-table command handling
//
// Contract
// [R1] host keeps select high for wake time
// [R2] ABh plus three dummies returns device ID
// [R3] device ID repeats until select rises
// [R4] wake from deep sleep delayed, else immediate
// [R5] ABh not decoded during write cycles
// [R6] ABh returns ID without prior deep sleep
// [R7] 90h address 0: maker then device ID
// [R8] 90h address 1: device ID first
// [R9] 90h and 9Fh refused in quad mode
// [R10] 9Fh returns maker, type, capacity bytes
// [R11] 9Fh not decoded during erase or program
// [R12] host avoids 9Fh during deep sleep
// [R13] 3Ah enters secure mode, sector 127 mapped
// [R14] protect bit reads as secure lock bit
// [R15] big erases and suspend refused in secure mode
// [R16] other sectors writable only when unlocked
// [R17] 04h leaves secure mode
// [R18] secure sector erased only by sector erase
// [R19] 5Ah, address, dummy, then table bytes
// [R20] table address increments and wraps to zero
// [R21] 5Ah rejected during write cycles
// [R22] table holds signature, header, basic table
// [R23] deep sleep ignores all but ABh
// [R24] partial opcode dropped on deselect
`timescale 1ns/1ps

module flash_id_cmd #(
  parameter logic [7:0] MAKER_ID        = 8'h5e, // arbitrary value
  parameter logic [7:0] DEVICE_ID       = 8'h12, // arbitrary value
  parameter logic [7:0] MEM_TYPE        = 8'h38, // arbitrary value
  parameter logic [7:0] CAPACITY        = 8'h13, // arbitrary value
  parameter int         WAKE_TIME_NS    = 3000,
  parameter int         WAKE_ID_TIME_NS = 1800
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        chipSelN,
  input  wire logic        serialClk,
  input  wire logic        serial_in,
  input  wire logic        eraseProgBusy,
  input  wire logic        statusWriteBusy,
  input  wire logic        quadCmdMode,
  input  wire logic        status_protect_bit,
  input  wire logic        deepSleepReq,
  input  wire logic [23:0] arrayAddr,
  output logic             serialOut,
  output logic             serialOutEn,
  output logic             deep_sleep,
  output logic             standbyReady,
  output logic             secureMode,
  output logic             secureLockBit,
  output logic             secureHit,
  output logic             bigEraseAllowed,
  output logic             suspendAllowed,
  output logic             otherWriteAllowed,
  output logic             secureEraseAllowed,
  output logic             opcodeValid,
  output logic [7:0]       opcodeOut
);

  localparam int CLK_PERIOD_NS_I = flash_id_pkg::CLK_PERIOD_NS;
  localparam int AW = flash_id_pkg::TABLE_AW;
  localparam logic [15:0] WAKE_CNT =
    16'((WAKE_TIME_NS + CLK_PERIOD_NS_I - 1) / CLK_PERIOD_NS_I);
  localparam logic [15:0] WAKE_ID_CNT =
    16'((WAKE_ID_TIME_NS + CLK_PERIOD_NS_I - 1) / CLK_PERIOD_NS_I);

  // pin synchronisers
  logic csSync1_q, csSync2_q, csPrev_q;
  logic sckSync1_q, sckSync2_q, sckPrev_q;
  logic sinSync1_q, sinSync2_q;

  // command engine
  flash_id_pkg::state_e   state_q;
  flash_id_pkg::outmode_e outMode_q;
  logic [4:0]   bitCnt_q;
  logic [7:0]   opc_q;
  logic [23:0]  shiftIn_q;
  logic         cmdOk_q;

  // output engine
  logic [2:0]    outBit_q;
  logic [1:0]    byteCnt_q;
  logic [AW-1:0] addr_q;
  logic          swap_q;

  // mode state
  logic         waking_q;
  logic [15:0]  wakeCnt_q;

  logic         csRise, sckRise, sckFall, busyAny;
  logic [7:0]   newOp;
  logic [23:0]  addrNew;
  logic [7:0]   curByte;
  logic         addrLoad;
  flash_id_pkg::state_e   decState;
  flash_id_pkg::outmode_e decMode;
  logic         decOk, decFwd;

  // discoverable parameter table
  function automatic logic [7:0] tableByte(input logic [AW-1:0] a);
    case (a)
      7'h00: tableByte = 8'h53; // [R22]
      7'h01: tableByte = 8'h46;
      7'h02: tableByte = 8'h44;
      7'h03: tableByte = 8'h50;
      7'h04: tableByte = 8'h00;
      7'h05: tableByte = 8'h01;
      7'h06: tableByte = 8'h00;
      7'h08: tableByte = 8'h00;
      7'h09: tableByte = 8'h00;
      7'h0a: tableByte = 8'h01;
      7'h0b: tableByte = 8'h09;
      7'h0c: tableByte = 8'h30;
      7'h0d: tableByte = 8'h00;
      7'h0e: tableByte = 8'h00;
      7'h30: tableByte = 8'he5;
      7'h31: tableByte = 8'h20;
      7'h32: tableByte = 8'hf1;
      7'h36: tableByte = 8'h3f;
      7'h37: tableByte = 8'h00;
      7'h38: tableByte = 8'h44;
      7'h39: tableByte = 8'heb;
      7'h3a: tableByte = 8'h08;
      7'h3b: tableByte = 8'h6b;
      7'h3c: tableByte = 8'h08;
      7'h3d: tableByte = 8'h3b;
      7'h3e: tableByte = 8'h04;
      7'h3f: tableByte = 8'hbb;
      7'h40: tableByte = 8'hfe;
      7'h46: tableByte = 8'h00;
      7'h4a: tableByte = 8'h44;
      7'h4b: tableByte = 8'heb;
      7'h4c: tableByte = 8'h0c;
      7'h4d: tableByte = 8'h20;
      7'h4e: tableByte = 8'h0f;
      7'h4f: tableByte = 8'h52;
      7'h50: tableByte = 8'h10;
      7'h51: tableByte = 8'hd8;
      7'h52: tableByte = 8'h00;
      // reserved and unused entries read all ones
      default: tableByte = 8'hff;
    endcase
  endfunction

  // pins come from the host's domain: two flops before any use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      csSync1_q  <= 1'b1;
      csSync2_q  <= 1'b1;
      csPrev_q   <= 1'b1;
      sckSync1_q <= 1'b0;
      sckSync2_q <= 1'b0;
      sckPrev_q  <= 1'b0;
      sinSync1_q <= 1'b0;
      sinSync2_q <= 1'b0;
    end else if (clkEn) begin
      csSync1_q  <= chipSelN;
      csSync2_q  <= csSync1_q;
      csPrev_q   <= csSync2_q;
      sckSync1_q <= serialClk;
      sckSync2_q <= sckSync1_q;
      sckPrev_q  <= sckSync2_q;
      sinSync1_q <= serial_in;
      sinSync2_q <= sinSync1_q;
    end
  end

  assign csRise   = csSync2_q & ~csPrev_q;
  assign sckRise  = sckSync2_q & ~sckPrev_q & ~csSync2_q;
  assign sckFall  = ~sckSync2_q & sckPrev_q & ~csSync2_q;
  assign busyAny  = eraseProgBusy | statusWriteBusy;
  assign newOp    = {opc_q[6:0], sinSync2_q};
  assign addrNew  = {shiftIn_q[22:0], sinSync2_q};
  assign addrLoad = (state_q == flash_id_pkg::ST_ADDR) && sckRise &&
                    (bitCnt_q == flash_id_pkg::ADDR_LAST_BIT);

  // opcode decode at the eighth bit
  always_comb begin
    decState = flash_id_pkg::ST_SKIP;
    decMode  = flash_id_pkg::OM_DEV;
    decOk    = 1'b0;
    decFwd   = 1'b0;
    if (deep_sleep) begin
      if (newOp == flash_id_pkg::OP_WAKE_ID) begin // [R23]
        decState = flash_id_pkg::ST_ADDR;
        decOk    = 1'b1;
      end
    end else begin
      case (newOp)
        flash_id_pkg::OP_WAKE_ID: begin
          if (!busyAny) begin // [R5] [R6]
            decState = flash_id_pkg::ST_ADDR;
            decOk    = 1'b1;
          end
        end
        flash_id_pkg::OP_MAKER_DEV: begin
          if (!quadCmdMode) begin // [R9]
            decState = flash_id_pkg::ST_ADDR;
            decMode  = flash_id_pkg::OM_MAKER;
            decOk    = 1'b1;
          end
        end
        flash_id_pkg::OP_STD_ID: begin
          if (!quadCmdMode && !eraseProgBusy) begin // [R9] [R11]
            decState = flash_id_pkg::ST_OUT;
            decMode  = flash_id_pkg::OM_STD;
            decOk    = 1'b1;
          end
        end
        flash_id_pkg::OP_TABLE_READ: begin
          if (!busyAny) begin // [R21]
            decState = flash_id_pkg::ST_ADDR;
            decMode  = flash_id_pkg::OM_TABLE;
            decOk    = 1'b1;
          end
        end
        flash_id_pkg::OP_SECURE_ENTER: decOk = 1'b1;
        flash_id_pkg::OP_LATCH_CLEAR: begin
          // write-latch logic elsewhere also needs this one
          decOk  = 1'b1;
          decFwd = 1'b1;
        end
        default: decFwd = 1'b1;
      endcase
    end
  end

  // command engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= flash_id_pkg::ST_IDLE;
      outMode_q   <= flash_id_pkg::OM_DEV;
      bitCnt_q    <= 5'h00;
      opc_q       <= 8'h00;
      shiftIn_q   <= 24'h000000;
      cmdOk_q     <= 1'b0;
      opcodeValid <= 1'b0;
      opcodeOut   <= 8'h00;
    end else if (clkEn) begin
      opcodeValid <= 1'b0;
      if (csSync2_q) begin
        state_q  <= flash_id_pkg::ST_IDLE; // [R24]
        bitCnt_q <= 5'h00;
      end else begin
        case (state_q)
          flash_id_pkg::ST_IDLE: begin
            cmdOk_q <= 1'b0;
            // a selection during the wake delay is not served
            if (waking_q) begin
              state_q <= flash_id_pkg::ST_SKIP; // [R1]
            end else begin
              state_q <= flash_id_pkg::ST_CMD;
            end
          end
          flash_id_pkg::ST_CMD: begin
            if (sckRise) begin
              opc_q    <= newOp;
              bitCnt_q <= bitCnt_q + 5'd1;
              if (bitCnt_q == flash_id_pkg::OPCODE_LAST_BIT) begin
                bitCnt_q    <= 5'h00;
                state_q     <= decState;
                outMode_q   <= decMode;
                cmdOk_q     <= decOk;
                opcodeValid <= decFwd;
                opcodeOut   <= newOp;
              end
            end
          end
          flash_id_pkg::ST_ADDR: begin
            if (sckRise) begin
              shiftIn_q <= addrNew;
              bitCnt_q  <= bitCnt_q + 5'd1;
              if (bitCnt_q == flash_id_pkg::ADDR_LAST_BIT) begin
                bitCnt_q <= 5'h00;
                if (outMode_q == flash_id_pkg::OM_TABLE) begin
                  state_q <= flash_id_pkg::ST_DUMMY; // [R19]
                end else begin
                  state_q <= flash_id_pkg::ST_OUT; // [R2] [R7]
                end
              end
            end
          end
          flash_id_pkg::ST_DUMMY: begin
            if (sckRise) begin
              bitCnt_q <= bitCnt_q + 5'd1;
              if (bitCnt_q == flash_id_pkg::DUMMY_LAST_BIT) begin
                bitCnt_q <= 5'h00;
                state_q  <= flash_id_pkg::ST_OUT; // [R19]
              end
            end
          end
          flash_id_pkg::ST_OUT: state_q <= flash_id_pkg::ST_OUT;
          flash_id_pkg::ST_SKIP: state_q <= flash_id_pkg::ST_SKIP;
          default: state_q <= flash_id_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // byte presented on the data line
  always_comb begin
    case (outMode_q)
      flash_id_pkg::OM_DEV: curByte = DEVICE_ID; // [R3]
      flash_id_pkg::OM_MAKER: begin
        if (byteCnt_q[0] ^ swap_q) begin // [R7] [R8]
          curByte = DEVICE_ID;
        end else begin
          curByte = MAKER_ID;
        end
      end
      flash_id_pkg::OM_STD: begin
        case (byteCnt_q) // [R10]
          2'd0: curByte = MAKER_ID;
          2'd1: curByte = MEM_TYPE;
          default: curByte = CAPACITY;
        endcase
      end
      default: curByte = tableByte(addr_q); // [R22]
    endcase
  end

  // output engine: shifts on the host's falling clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
      outBit_q    <= 3'h0;
      byteCnt_q   <= 2'h0;
      addr_q      <= '0;
      swap_q      <= 1'b0;
    end else if (clkEn) begin
      if (state_q != flash_id_pkg::ST_OUT) begin
        serialOutEn <= 1'b0; // [R10]
        outBit_q    <= 3'h0;
        byteCnt_q   <= 2'h0;
        if (addrLoad) begin
          addr_q <= addrNew[AW-1:0]; // [R19]
          swap_q <= addrNew[0]; // [R8]
        end
      end else if (sckFall) begin
        serialOutEn <= 1'b1;
        serialOut   <= curByte[flash_id_pkg::BYTE_LAST_BIT - outBit_q]; // [R2]
        outBit_q    <= outBit_q + 3'd1;
        if (outBit_q == flash_id_pkg::BYTE_LAST_BIT) begin
          // natural wrap of the counter takes the top entry back to zero
          addr_q <= addr_q + 1'b1; // [R20]
          if (outMode_q == flash_id_pkg::OM_STD &&
              byteCnt_q == flash_id_pkg::STD_ID_LAST) begin
            byteCnt_q <= 2'h0;
          end else begin
            byteCnt_q <= byteCnt_q + 2'd1;
          end
        end
      end
    end
  end

  // sleep entered on request; wake and secure-sector mode committed on deselect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deep_sleep <= flash_id_pkg::RST_DEEP_SLEEP;
      secureMode <= flash_id_pkg::RST_SECURE_MODE;
      waking_q   <= 1'b0;
      wakeCnt_q  <= flash_id_pkg::RST_WAKE_CNT;
    end else if (clkEn) begin
      if (waking_q) begin
        if (wakeCnt_q == 16'h0000) begin
          waking_q   <= 1'b0;
          deep_sleep <= 1'b0; // [R4]
        end else begin
          wakeCnt_q <= wakeCnt_q - 16'd1;
        end
      end else if (csRise && cmdOk_q) begin
        if (deep_sleep) begin
          if (opc_q == flash_id_pkg::OP_WAKE_ID) begin
            waking_q <= 1'b1; // [R4]
            // an id read that reached output uses the second delay
            if (state_q == flash_id_pkg::ST_OUT) begin
              wakeCnt_q <= WAKE_ID_CNT - 16'd1;
            end else begin
              wakeCnt_q <= WAKE_CNT - 16'd1; // [R1]
            end
          end
        end else if (opc_q == flash_id_pkg::OP_SECURE_ENTER) begin
          secureMode <= 1'b1; // [R13]
        end else if (opc_q == flash_id_pkg::OP_LATCH_CLEAR) begin
          secureMode <= 1'b0; // [R17]
        end
      end else if (deepSleepReq && !busyAny) begin
        deep_sleep <= 1'b1;
      end
    end
  end

  // permissions seen by the erase, program and status logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standbyReady       <= 1'b1;
      secureLockBit      <= 1'b0;
      secureHit          <= 1'b0;
      bigEraseAllowed    <= flash_id_pkg::RST_ALLOWED;
      suspendAllowed     <= flash_id_pkg::RST_ALLOWED;
      otherWriteAllowed  <= flash_id_pkg::RST_ALLOWED;
      secureEraseAllowed <= 1'b0;
    end else if (clkEn) begin
      standbyReady       <= !deep_sleep && !waking_q; // [R4]
      secureLockBit      <= secureMode & status_protect_bit; // [R14]
      secureHit          <= secureMode &&
                            arrayAddr >= flash_id_pkg::SECURE_BASE &&
                            arrayAddr <= flash_id_pkg::SECURE_LAST; // [R13]
      bigEraseAllowed    <= !secureMode; // [R15]
      suspendAllowed     <= !secureMode; // [R15]
      otherWriteAllowed  <= !secureMode || !status_protect_bit; // [R16]
      secureEraseAllowed <= secureMode; // [R18]
    end
  end

endmodule // flash_id_cmd

// >>> flash_id_cmd_assertions.sv
// port checks for the flash identification command block
`timescale 1ns/1ps

module flash_id_cmd_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        chipSelN,
  input wire logic        status_protect_bit,
  input wire logic [23:0] arrayAddr,
  input wire logic        serialOutEn,
  input wire logic        deep_sleep,
  input wire logic        standbyReady,
  input wire logic        secureMode,
  input wire logic        secureLockBit,
  input wire logic        secureHit,
  input wire logic        bigEraseAllowed,
  input wire logic        suspendAllowed,
  input wire logic        otherWriteAllowed,
  input wire logic        secureEraseAllowed,
  input wire logic        opcodeValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // three settled cycles cover the one-clock registration lag
  sequence sSecure;
    secureMode [*3];
  endsequence
  sequence sPlain;
    !secureMode [*3];
  endsequence
  sequence sLocked;
    (secureMode && status_protect_bit) [*3];
  endsequence
  sequence sInWindow;
    (secureMode && arrayAddr >= flash_id_pkg::SECURE_BASE
     && arrayAddr <= flash_id_pkg::SECURE_LAST) [*3];
  endsequence

  a_rst_quiet: assert property (disable iff (1'b0) sys_rst ##1 sys_rst
    |-> !serialOutEn && standbyReady && !secureMode && !deep_sleep)
    else $error("outputs not at reset values");
  a_big_erase: assert property (sSecure |-> !bigEraseAllowed
    && !suspendAllowed && secureEraseAllowed)
    else $error("erase permissions wrong in secure mode");
  a_lock_bit: assert property (sLocked |-> secureLockBit
    && !otherWriteAllowed)
    else $error("lock bit not applied");
  a_plain_free: assert property (sPlain |-> !secureLockBit
    && otherWriteAllowed && bigEraseAllowed && !secureEraseAllowed)
    else $error("permissions wrong outside secure mode");
  a_secure_hit: assert property (sInWindow |-> secureHit)
    else $error("secure window not hit");
  a_hit_outside: assert property (
    (arrayAddr > flash_id_pkg::SECURE_LAST) [*3] |-> !secureHit)
    else $error("hit outside secure window");
  a_out_idle: assert property (chipSelN [*8] |-> !serialOutEn)
    else $error("output driven while deselected");
  a_sleep_quiet: assert property (
    deep_sleep && $past(deep_sleep) |-> !opcodeValid)
    else $error("opcode forwarded in deep sleep");
  a_sleep_ready: assert property (
    deep_sleep && $past(deep_sleep) |-> !standbyReady)
    else $error("ready while asleep");
  a_wake_ready: assert property ($fell(deep_sleep) |=> standbyReady)
    else $error("standby late after wake");
endmodule // flash_id_cmd_assertions

bind flash_id_cmd flash_id_cmd_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .chipSelN(chipSelN),
  .status_protect_bit(status_protect_bit), .arrayAddr(arrayAddr),
  .serialOutEn(serialOutEn), .deep_sleep(deep_sleep),
  .standbyReady(standbyReady), .secureMode(secureMode),
  .secureLockBit(secureLockBit), .secureHit(secureHit),
  .bigEraseAllowed(bigEraseAllowed), .suspendAllowed(suspendAllowed),
  .otherWriteAllowed(otherWriteAllowed),
  .secureEraseAllowed(secureEraseAllowed), .opcodeValid(opcodeValid)
);

// >>> spi_host_model.sv
// host serial controller model: select, link clock, data, capture
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk,
  output logic      chipSelN,
  output logic      serialClk,
  output logic      serial_in,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic [31:0] rx;
  logic        sawEn;

  initial begin
    chipSelN  = 1'b1;
    serialClk = 1'b0;
    serial_in = 1'b0;
    rx        = '0;
    sawEn     = 1'b0;
  end

  // 80 ns half period of the 160 ns link clock
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // data set in the low phase, device samples at rise, we capture there
  task automatic pulse(input logic b);
    serial_in = b;
    half();
    serialClk = 1'b1;
    rx = {rx[30:0], serialOut};
    sawEn = sawEn | serialOutEn;
    half();
    serialClk = 1'b0;
  endtask

  task automatic frame(input logic [7:0] op, input int opBits,
                       input logic [31:0] tail, input int tailBits,
                       input int outBits);
    sawEn = 1'b0;
    chipSelN = 1'b0;
    half();
    for (int i = 7; i > 7 - opBits; i--) pulse(op[i]);
    for (int i = tailBits - 1; i >= 0; i--) pulse(tail[i]);
    rx = '0;
    // host data is idle during output, so keep it moving
    for (int i = 0; i < outBits; i++) pulse(~serial_in);
    half();
    chipSelN = 1'b1;
    serial_in = ~serial_in;
    // clock stands still low between frames
    half();
  endtask
endmodule // spi_host_model

// >>> tb_top.sv
// self-checking bench for the flash identification command block
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] MAKER = 8'h5e; // arbitrary value
  localparam logic [7:0] DEVID = 8'h12; // arbitrary value
  localparam logic [7:0] MTYPE = 8'h38; // arbitrary value
  localparam logic [7:0] CAPAC = 8'h13; // arbitrary value
  typedef struct {
    logic [7:0]  op;
    logic [31:0] tail;
    int          tb;
    int          nb;
    logic [31:0] exp;
  } row_s;
  row_s rows [7] = '{
    '{8'hab, 32'h0, 24, 16, {16'h0, DEVID, DEVID}},
    '{8'h90, 32'h0, 24, 16, {16'h0, MAKER, DEVID}},
    '{8'h90, 32'h1, 24, 16, {16'h0, DEVID, MAKER}},
    '{8'h9f, 32'h0, 0, 32, {MAKER, MTYPE, CAPAC, MAKER}},
    '{8'h5a, 32'h0, 32, 32, 32'h53464450},
    '{8'h5a, 32'hc00, 32, 32, 32'h300000ff},
    '{8'h5a, 32'h7f00, 32, 24, 32'h00ff5346}};

  logic        clk, sys_rst, eraseProgBusy, statusWriteBusy;
  logic        quadCmdMode, status_protect_bit, deepSleepReq;
  logic [23:0] arrayAddr;
  wire logic   chipSelN, serialClk, serial_in, serialOut, serialOutEn;
  wire logic   deep_sleep, standbyReady, secureMode, secureLockBit;
  wire logic   secureHit, bigEraseAllowed, suspendAllowed, opcodeValid;
  wire logic   otherWriteAllowed, secureEraseAllowed;
  wire logic [7:0] opcodeOut;
  int          n_errors = 0;
  int          checks = 0;

  spi_host_model u_host (.clk(clk), .chipSelN(chipSelN),
    .serialClk(serialClk), .serial_in(serial_in),
    .serialOut(serialOut), .serialOutEn(serialOutEn));

  // short wake delays keep the run brief
  flash_id_cmd #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID), .MEM_TYPE(MTYPE),
    .CAPACITY(CAPAC), .WAKE_TIME_NS(200), .WAKE_ID_TIME_NS(200)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .chipSelN(chipSelN),
    .serialClk(serialClk), .serial_in(serial_in),
    .eraseProgBusy(eraseProgBusy), .statusWriteBusy(statusWriteBusy),
    .quadCmdMode(quadCmdMode), .status_protect_bit(status_protect_bit),
    .deepSleepReq(deepSleepReq), .arrayAddr(arrayAddr),
    .serialOut(serialOut), .serialOutEn(serialOutEn),
    .deep_sleep(deep_sleep), .standbyReady(standbyReady),
    .secureMode(secureMode), .secureLockBit(secureLockBit),
    .secureHit(secureHit), .bigEraseAllowed(bigEraseAllowed),
    .suspendAllowed(suspendAllowed), .otherWriteAllowed(otherWriteAllowed),
    .secureEraseAllowed(secureEraseAllowed), .opcodeValid(opcodeValid),
    .opcodeOut(opcodeOut));

  always #5 clk = ~clk;

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chkv({31'h0, got}, {31'h0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic quiet(input logic [7:0] op, input int tb);
    u_host.frame(op, 8, 32'h0, tb, 8);
    chkb(u_host.sawEn, 1'b0);
  endtask

  task automatic sleep();
    deepSleepReq = 1'b1;
    step(1);
    deepSleepReq = 1'b0;
    step(3);
  endtask

  // select stays high for the whole wake delay
  task automatic waitReady();
    for (int i = 0; i < 100 && standbyReady !== 1'b1; i++) step(1);
    chkb(standbyReady, 1'b1);
  endtask

  task automatic results();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #800_000;
    n_errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {eraseProgBusy, statusWriteBusy, quadCmdMode} = 3'b000;
    {status_protect_bit, deepSleepReq} = 2'b00;
    arrayAddr = 24'h0;
    step(6);
    sys_rst = 1'b0;
    step(3);
    foreach (rows[i]) begin
      u_host.frame(rows[i].op, 8, rows[i].tail, rows[i].tb, rows[i].nb);
      chkv(u_host.rx, rows[i].exp);
    end
    quadCmdMode = 1'b1;
    quiet(flash_id_pkg::OP_MAKER_DEV, 24);
    quiet(flash_id_pkg::OP_STD_ID, 0);
    quadCmdMode = 1'b0;
    eraseProgBusy = 1'b1;
    quiet(flash_id_pkg::OP_STD_ID, 0);
    quiet(flash_id_pkg::OP_TABLE_READ, 32);
    quiet(flash_id_pkg::OP_WAKE_ID, 24);
    eraseProgBusy = 1'b0;
    statusWriteBusy = 1'b1;
    quiet(flash_id_pkg::OP_WAKE_ID, 24);
    quiet(flash_id_pkg::OP_TABLE_READ, 32);
    statusWriteBusy = 1'b0;
    u_host.frame(flash_id_pkg::OP_STD_ID, 4, 32'h0, 0, 0);
    chkb(u_host.sawEn, 1'b0);
    u_host.frame(flash_id_pkg::OP_STD_ID, 8, 32'h0, 0, 24);
    chkv(u_host.rx, {8'h0, MAKER, MTYPE, CAPAC});
    u_host.frame(flash_id_pkg::OP_SECURE_ENTER, 8, 32'h0, 0, 0);
    arrayAddr = flash_id_pkg::SECURE_LAST;
    step(4);
    chkb(secureMode, 1'b1);
    chkb(secureHit, 1'b1);
    chkb(bigEraseAllowed, 1'b0);
    chkb(suspendAllowed, 1'b0);
    chkb(secureEraseAllowed, 1'b1);
    chkb(otherWriteAllowed, 1'b1);
    status_protect_bit = 1'b1;
    arrayAddr = flash_id_pkg::SECURE_LAST + 24'h1;
    step(4);
    chkb(secureLockBit, 1'b1);
    chkb(otherWriteAllowed, 1'b0);
    chkb(secureHit, 1'b0);
    u_host.frame(flash_id_pkg::OP_LATCH_CLEAR, 8, 32'h0, 0, 0);
    chkb(secureMode, 1'b0);
    chkv({24'h0, opcodeOut}, {24'h0, flash_id_pkg::OP_LATCH_CLEAR});
    status_protect_bit = 1'b0;
    u_host.frame(flash_id_pkg::OP_SECURE_ENTER, 8, 32'h0, 0, 0);
    sys_rst = 1'b1;
    step(4);
    chkb(secureMode, 1'b0);
    chkb(standbyReady, 1'b1);
    sys_rst = 1'b0;
    step(3);
    sleep();
    chkb(deep_sleep, 1'b1);
    quiet(flash_id_pkg::OP_MAKER_DEV, 24);
    u_host.frame(flash_id_pkg::OP_WAKE_ID, 8, 32'h0, 0, 0);
    chkb(standbyReady, 1'b0);
    waitReady();
    chkb(deep_sleep, 1'b0);
    sleep();
    u_host.frame(flash_id_pkg::OP_WAKE_ID, 8, 32'h0, 24, 8);
    chkv(u_host.rx, {24'h0, DEVID});
    waitReady();
    chkb(deep_sleep, 1'b0);
    results();
  end
endmodule // tb_top
